// file: src/synth_cfg_pkg.sv
package synth_cfg_pkg;
  // ****************************************
  // Register select codes
  // ****************************************
  localparam logic [3:0] SEL_INT = 4'h0;
  localparam logic [3:0] SEL_FRAC = 4'h1;
  localparam logic [3:0] SEL_AUX_LO = 4'h2;
  localparam logic [3:0] SEL_REF = 4'h4;
  localparam logic [3:0] SEL_ADC = 4'ha;
  localparam logic [3:0] SEL_HOLD = 4'hb;
  localparam logic [3:0] SEL_RESYNC = 4'hc;
  localparam logic [3:0] SEL_AUX_UP = 4'hd;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int SEL_LSB = 0;
  localparam int INT_LSB = 4;
  localparam int FRAC_LSB = 4;
  localparam int AUX_MOD_LSB = 4;
  localparam int AUX_FRAC_LSB = 18;
  localparam int R_LSB = 15;
  localparam int HALVE_BIT = 25;
  localparam int DOUBLE_BIT = 26;
  localparam int ADC_DIV_LSB = 6;
  localparam int CONV_BIT = 5;
  localparam int PWR_BIT = 4;
  localparam int HOLD_BIT = 24;
  localparam int RESYNC_LSB = 12;
  localparam int HALF_W = 14;
  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [9:0] R_RESET = 10'h001;
  localparam logic [19:0] RESYNC_RESET = 20'hfffff;
  localparam logic [7:0] ADC_DIV_RESET = 8'h01;
  localparam logic [4:0] CONV_TICKS = 5'h10;
  localparam logic [24:0] MAIN_MODULUS = 25'h1000000;
  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [7:0] div;
    logic conv;
    logic pwr;
  } adc_ctl_s;
  typedef struct packed {
    logic [13:0] frac;
    logic [13:0] modulus;
  } aux_half_s;
endpackage

// file: src/synth_calib_register_sequencer.sv
`timescale 1ns/1ps
// What this block does
// - ADC clock is phase-detector tick divided by 8-bit divider field.
// - Reference divide factor reads as one until register 4 is written.
// - With convert-on-write and ADC power both set, each register 10 write starts a conversion.
// - ADC power bit one powers the temperature ADC.
// - Band hold set keeps oscillator band through counter reset.
// - Register 12 resync count; resync fires after that many detector periods.
// - Aux fraction is upper half times 2^14 plus lower half.
// - Aux modulus is upper half times 2^14 plus lower half.
// - Register 13 fields take effect only at next register 0 write.
// - Ratio changes only on a register 0 write; R and halve from register 4 apply at once.
// - Ratio is integer plus fractions over fixed 2^24 main modulus.
// - Detector rate is reference over R times (1+T); the doubler D is only reported.
module synth_calib_register_sequencer
  import synth_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic word_load_strobe,
  input wire logic ref_in,
  output logic [15:0] int_value,
  output logic [23:0] main_fraction,
  output logic [27:0] aux_fraction,
  output logic [27:0] aux_modulus,
  output logic [24:0] main_modulus,
  output logic [9:0] ref_divider,
  output logic ref_doubler,
  output logic ref_halve,
  output logic phase_detector_tick,
  output logic adc_clk_en,
  output logic temp_adc_power,
  output logic adc_busy,
  output logic hold_oscillator_band,
  output logic band_reset,
  output logic resync_pulse
);
  import synth_cfg_pkg::*;

  // ****************************************
  // Pin synchroniser and serial shifter
  // ****************************************
  logic [3:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  logic [31:0] shift_q, shift_d, word_q, word_d;
  logic wr_q, wr_d;
  logic sclk_rise, le_rise, ref_rise;

  // Change counts only when second and third stages agree
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
  end

  assign sclk_rise = filt_d[0] & ~filt_q[0];
  assign le_rise = filt_d[2] & ~filt_q[2];
  assign ref_rise = filt_d[3] & ~filt_q[3];

  // Shift MSB first; whole word latched on load strobe rise
  always_comb
  begin
    shift_d = shift_q;
    word_d = word_q;
    wr_d = 1'b0;
    if (sclk_rise)
      shift_d = {shift_q[30:0], filt_d[1]};
    if (le_rise)
    begin
      word_d = shift_q;
      wr_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      filt_q <= 4'h0;
      shift_q <= 32'h0;
      word_q <= 32'h0;
      wr_q <= 1'b0;
    end
    else
    begin
      s1_q <= {ref_in, word_load_strobe, serial_data, serial_clk};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      shift_q <= shift_d;
      word_q <= word_d;
      wr_q <= wr_d;
    end
  end

  function automatic logic hit(input logic [3:0] code);
    hit = wr_q && (word_q[SEL_LSB +: 4] == code);
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  adc_ctl_s adc_q, adc_d;
  aux_half_s up_stage_q, up_stage_d, up_q, up_d;
  aux_half_s lo_stage_q, lo_stage_d, lo_q, lo_d;
  logic [15:0] int_q, int_d;
  logic [23:0] frac_stage_q, frac_stage_d, frac_q, frac_d;
  logic [9:0] r_q, r_d;
  logic dbl_q, dbl_d, hlv_q, hlv_d, hold_q, hold_d;
  logic [19:0] rs_count_q, rs_count_d;
  logic brst_q, brst_d;

  // Staged values go live together so a half update never shows
  always_comb
  begin
    adc_d = adc_q;
    up_stage_d = up_stage_q;
    lo_stage_d = lo_stage_q;
    frac_stage_d = frac_stage_q;
    up_d = up_q;
    lo_d = lo_q;
    frac_d = frac_q;
    int_d = int_q;
    r_d = r_q;
    dbl_d = dbl_q;
    hlv_d = hlv_q;
    hold_d = hold_q;
    rs_count_d = rs_count_q;
    brst_d = 1'b0;
    if (hit(SEL_ADC))
    begin
      adc_d.div = word_q[ADC_DIV_LSB +: 8];
      adc_d.conv = word_q[CONV_BIT];
      adc_d.pwr = word_q[PWR_BIT];
    end
    if (hit(SEL_HOLD))
      hold_d = word_q[HOLD_BIT];
    if (hit(SEL_RESYNC))
      rs_count_d = word_q[RESYNC_LSB +: 20];
    if (hit(SEL_AUX_UP))
    begin
      up_stage_d.frac = word_q[AUX_FRAC_LSB +: HALF_W];
      up_stage_d.modulus = word_q[AUX_MOD_LSB +: HALF_W];
    end
    if (hit(SEL_AUX_LO))
    begin
      lo_stage_d.frac = word_q[AUX_FRAC_LSB +: HALF_W];
      lo_stage_d.modulus = word_q[AUX_MOD_LSB +: HALF_W];
    end
    if (hit(SEL_FRAC))
      frac_stage_d = word_q[FRAC_LSB +: 24];
    if (hit(SEL_REF))
    begin
      r_d = word_q[R_LSB +: 10];
      dbl_d = word_q[DOUBLE_BIT];
      hlv_d = word_q[HALVE_BIT];
    end
    if (hit(SEL_INT))
    begin
      int_d = word_q[INT_LSB +: 16];
      frac_d = frac_stage_q;
      up_d = up_stage_q;
      lo_d = lo_stage_q;
      brst_d = ~hold_q;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      adc_q <= '{div: ADC_DIV_RESET, conv: 1'b0, pwr: 1'b0};
      up_stage_q <= '0;
      lo_stage_q <= '0;
      up_q <= '0;
      lo_q <= '0;
      frac_stage_q <= 24'h0;
      frac_q <= 24'h0;
      int_q <= 16'h0;
      r_q <= R_RESET;
      dbl_q <= 1'b0;
      hlv_q <= 1'b0;
      hold_q <= 1'b0;
      rs_count_q <= RESYNC_RESET;
      brst_q <= 1'b0;
    end
    else
    begin
      adc_q <= adc_d;
      up_stage_q <= up_stage_d;
      lo_stage_q <= lo_stage_d;
      up_q <= up_d;
      lo_q <= lo_d;
      frac_stage_q <= frac_stage_d;
      frac_q <= frac_d;
      int_q <= int_d;
      r_q <= r_d;
      dbl_q <= dbl_d;
      hlv_q <= hlv_d;
      hold_q <= hold_d;
      rs_count_q <= rs_count_d;
      brst_q <= brst_d;
    end
  end

  // Full values built from halves
  assign aux_fraction = {up_q.frac, lo_q.frac};
  assign aux_modulus = {up_q.modulus, lo_q.modulus};
  assign main_modulus = MAIN_MODULUS;
  assign int_value = int_q;
  assign main_fraction = frac_q;
  assign ref_divider = r_q;
  assign ref_doubler = dbl_q;
  assign ref_halve = hlv_q;
  assign hold_oscillator_band = hold_q;
  assign band_reset = brst_q;
  assign temp_adc_power = adc_q.pwr;

  // ****************************************
  // Detector, ADC and resync timing
  // ****************************************
  logic [10:0] rc_q, rc_d, r_span;
  logic [7:0] ac_q, ac_d, a_span;
  logic [4:0] cv_q, cv_d;
  logic [19:0] rt_q, rt_d;
  logic pfd_q, pfd_d, adc_q2, adc_d2, rs_q, rs_d, arm_q, arm_d;

  // Zero divider would stall, so it counts as one
  assign r_span = (r_q == 10'h0) ? 11'h001
                : (hlv_q ? {r_q, 1'b0} : {1'b0, r_q});
  assign a_span = (adc_q.div == 8'h0) ? 8'h01 : adc_q.div;

  always_comb
  begin
    rc_d = rc_q;
    ac_d = ac_q;
    cv_d = cv_q;
    rt_d = rt_q;
    arm_d = arm_q;
    pfd_d = 1'b0;
    adc_d2 = 1'b0;
    rs_d = 1'b0;
    if (ref_rise)
    begin
      // Doubler only reported; one clock cannot double the reference
      if (rc_q + 11'h001 >= r_span)
      begin
        rc_d = 11'h0;
        pfd_d = 1'b1;
      end
      else
        rc_d = rc_q + 11'h001;
    end
    if (pfd_q)
    begin
      if (ac_q + 8'h01 >= a_span)
      begin
        ac_d = 8'h0;
        adc_d2 = 1'b1;
      end
      else
        ac_d = ac_q + 8'h01;
    end
    if (adc_q2 && cv_q != 5'h0)
      cv_d = cv_q - 5'h01;
    if (hit(SEL_ADC) && word_q[CONV_BIT] && word_q[PWR_BIT])
      cv_d = CONV_TICKS;
    // Next power value, so a write that powers up may start at once
    if (!adc_d.pwr)
      cv_d = 5'h0;
    if (arm_q && pfd_q)
    begin
      if (rt_q + 20'h1 >= rs_count_q)
      begin
        rs_d = 1'b1;
        arm_d = 1'b0;
      end
      else
        rt_d = rt_q + 20'h1;
    end
    if (hit(SEL_INT))
    begin
      rt_d = 20'h0;
      arm_d = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rc_q <= 11'h0;
      ac_q <= 8'h0;
      cv_q <= 5'h0;
      rt_q <= 20'h0;
      arm_q <= 1'b0;
      pfd_q <= 1'b0;
      adc_q2 <= 1'b0;
      rs_q <= 1'b0;
    end
    else
    begin
      rc_q <= rc_d;
      ac_q <= ac_d;
      cv_q <= cv_d;
      rt_q <= rt_d;
      arm_q <= arm_d;
      pfd_q <= pfd_d;
      adc_q2 <= adc_d2;
      rs_q <= rs_d;
    end
  end

  assign phase_detector_tick = pfd_q;
  assign adc_clk_en = adc_q2;
  assign adc_busy = (cv_q != 5'h0);
  assign resync_pulse = rs_q;

  // ****************************************
  // Checks
  // ****************************************
  logic r_wr_q;
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      r_wr_q <= 1'b0;
    else if (hit(SEL_REF))
      r_wr_q <= 1'b1;
  end

  property p_adc_clk;
    @(posedge mclk) disable iff (sys_rst)
    adc_clk_en |-> $past(pfd_q) && $past(ac_q) == $past(a_span) - 8'h01;
  endproperty
  a_adc_clk: assert property (p_adc_clk) else $error("adc tick");

  property p_r_one;
    @(posedge mclk) disable iff (sys_rst) !r_wr_q |-> r_q == 10'h001;
  endproperty
  a_r_one: assert property (p_r_one) else $error("R not one");

  property p_conv;
    @(posedge mclk) disable iff (sys_rst)
    hit(SEL_ADC) && word_q[CONV_BIT] && word_q[PWR_BIT]
      |=> cv_q == CONV_TICKS && adc_busy;
  endproperty
  a_conv: assert property (p_conv) else $error("no conversion");

  property p_pwr;
    @(posedge mclk) disable iff (sys_rst) adc_busy |-> temp_adc_power;
  endproperty
  a_pwr: assert property (p_pwr) else $error("busy unpowered");

  property p_hold;
    @(posedge mclk) disable iff (sys_rst)
    hit(SEL_INT) |=> band_reset == !hold_oscillator_band;
  endproperty
  a_hold: assert property (p_hold) else $error("band reset");

  property p_resync;
    @(posedge mclk) disable iff (sys_rst)
    resync_pulse |-> $past(pfd_q)
      && $past(rt_q) + 20'h1 >= $past(rs_count_q);
  endproperty
  a_resync: assert property (p_resync) else $error("early resync");

  property p_aux_frac;
    @(posedge mclk) disable iff (sys_rst)
    hit(SEL_INT) |=> aux_fraction[27:14] == $past(up_stage_q.frac);
  endproperty
  a_aux_frac: assert property (p_aux_frac) else $error("frac up");

  property p_aux_mod;
    @(posedge mclk) disable iff (sys_rst)
    hit(SEL_INT) |=> aux_modulus[13:0] == $past(lo_stage_q.modulus);
  endproperty
  a_aux_mod: assert property (p_aux_mod) else $error("mod lo");

  property p_buffered;
    @(posedge mclk) disable iff (sys_rst)
    hit(SEL_AUX_UP) |=> $stable(aux_fraction) && $stable(aux_modulus);
  endproperty
  a_buffered: assert property (p_buffered) else $error("r13 live");

  property p_freq;
    @(posedge mclk) disable iff (sys_rst)
    !hit(SEL_INT) |=> $stable(int_value) && $stable(main_fraction);
  endproperty
  a_freq: assert property (p_freq) else $error("freq moved");

  property p_pfd;
    @(posedge mclk) disable iff (sys_rst)
    phase_detector_tick |-> $past(ref_rise);
  endproperty
  a_pfd: assert property (p_pfd) else $error("pfd tick");

  c_conv: cover property (@(posedge mclk) disable iff (sys_rst)
    adc_busy ##1 !adc_busy);
  c_resync: cover property (@(posedge mclk) disable iff (sys_rst)
    resync_pulse);
  c_apply: cover property (@(posedge mclk) disable iff (sys_rst)
    hit(SEL_AUX_UP) ##[1:400] hit(SEL_INT));
endmodule

// file: tb/host_serial_model.sv
`timescale 1ns/1ps
// ****************************************
// Host end of the three-wire word link
// ****************************************
module host_serial_model
(
  input wire logic mclk,
  output logic serial_clk,
  output logic serial_data,
  output logic word_load_strobe
);
  // Link clock stands still low between words
  initial
  begin
    serial_clk = 1'b0;
    serial_data = 1'b0;
    word_load_strobe = 1'b0;
  end
  // MSB first, each level held four cycles for the pin filter
  task automatic write_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      serial_data <= w[i];
      repeat (4) @(posedge mclk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      serial_clk <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    // Released data line flips, so a stale bit cannot pass
    serial_data <= ~w[0];
    word_load_strobe <= 1'b1;
    repeat (4) @(posedge mclk);
    word_load_strobe <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  // Wait given in whole cycles, already rounded up
  task automatic hold_off(input int cycles);
    repeat (cycles) @(posedge mclk);
  endtask
  // Fixed reserved pattern around the band hold bit
  function automatic logic [31:0] hold_word(input logic h);
    return 32'h00612000 | {7'h00, h, 24'h000000} | 32'h0000000b;
  endfunction
  // Small count so resync lands soon after the tune
  function automatic logic [31:0] resync_word(input logic [19:0] n);
    return {n, 8'h5f, 4'hc};
  endfunction
  // Divider is kept well under the 255 cap
  function automatic logic [31:0] adc_word(input logic [7:0] d,
                                            input logic c, input logic p);
    return {8'h00, 2'b11, 8'h00, d, c, p, 4'ha};
  endfunction
endmodule

// file: tb/synth_calib_register_sequencer_tb.sv
`timescale 1ns/1ps
module synth_calib_register_sequencer_tb;
  import synth_cfg_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, ref_in = 1'b0;
  logic serial_clk, serial_data, word_load_strobe;
  logic [15:0] int_value;
  logic [23:0] main_fraction;
  logic [27:0] aux_fraction, aux_modulus;
  logic [24:0] main_modulus;
  logic [9:0] ref_divider;
  logic ref_doubler, ref_halve, phase_detector_tick, adc_clk_en;
  logic temp_adc_power, adc_busy, hold_oscillator_band;
  logic band_reset, resync_pulse;
  logic [31:0] seed = 32'hcdd4fd0a;
  logic [15:0] exp_int = 16'h0000;
  logic [23:0] exp_fr = 24'h000000;
  logic [27:0] exp_af = 28'h0, exp_am = 28'h0;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  int adc_last = 0, adc_gap = 0, pfd_last = 0, pfd_gap = 0;
  int band_cnt = 0, tick_since = 0, resync_ticks = 0;
  always #50 mclk = ~mclk;
  synth_calib_register_sequencer synth_calib_register_sequencer_inst (
    .mclk(mclk), .sys_rst(sys_rst), .serial_clk(serial_clk),
    .serial_data(serial_data), .word_load_strobe(word_load_strobe),
    .ref_in(ref_in), .int_value(int_value),
    .main_fraction(main_fraction), .aux_fraction(aux_fraction),
    .aux_modulus(aux_modulus), .main_modulus(main_modulus),
    .ref_divider(ref_divider), .ref_doubler(ref_doubler),
    .ref_halve(ref_halve), .phase_detector_tick(phase_detector_tick),
    .adc_clk_en(adc_clk_en), .temp_adc_power(temp_adc_power),
    .adc_busy(adc_busy), .hold_oscillator_band(hold_oscillator_band),
    .band_reset(band_reset), .resync_pulse(resync_pulse));
  host_serial_model host_serial_model_inst (
    .mclk(mclk), .serial_clk(serial_clk), .serial_data(serial_data),
    .word_load_strobe(word_load_strobe));
  // ****************************************
  // Reference, pulse spacing and timeout
  // ****************************************
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    ref_in <= (cyc % 8) >= 3; // Rise every eight cycles
    if (adc_clk_en === 1'b1)
    begin
      adc_gap <= cyc - adc_last;
      adc_last <= cyc;
    end
    if (phase_detector_tick === 1'b1)
    begin
      pfd_gap <= cyc - pfd_last;
      pfd_last <= cyc;
    end
    if (band_reset === 1'b1)
      band_cnt <= band_cnt + 1;
    // Timer is armed in the commit cycle, so a tick there counts too
    if (band_reset === 1'b1)
      tick_since <= (phase_detector_tick === 1'b1) ? 1 : 0;
    else if (phase_detector_tick === 1'b1)
      tick_since <= tick_since + 1;
    if (resync_pulse === 1'b1)
      resync_ticks <= tick_since;
    if (cyc == 40000)
    begin
      mismatches++;
      close_out();
    end
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [31:0] w);
    host_serial_model_inst.write_word(w);
    repeat (6) @(posedge mclk);
    #1;
  endtask
  // ****************************************
  // Full tune: staged halves, wait, commit
  // ****************************************
  task automatic retune(input logic init, input logic hold);
    logic [13:0] uf, um, lf, lm;
    logic [23:0] fr;
    logic [15:0] iv;
    logic c, p;
    int b;
    seed = lfsr(seed);
    {um, uf} = seed[27:0];
    seed = lfsr(seed);
    {lm, lf} = seed[27:0];
    seed = lfsr(seed);
    {iv, fr} = {seed[31:16], seed[23:0]};
    seed = lfsr(seed);
    c = init | seed[0];
    p = init | seed[1];
    wr({uf, um, 4'hd});
    if (init)
    begin
      wr(host_serial_model_inst.resync_word(20'h00005));
      wr(host_serial_model_inst.hold_word(hold));
    end
    wr(host_serial_model_inst.adc_word(8'h03, c, p));
    check(temp_adc_power, p);
    check(adc_busy, c & p);
    if (init)
    begin
      wr({seed[31:4], 4'h9}); // Unknown select, ignored
      wr({5'h00, 2'b00, 10'h001, 11'h000, 4'h4});
    end
    wr({lf, lm, 4'h2});
    wr({4'h0, fr, 4'h1});
    check(aux_fraction, exp_af);
    check(aux_modulus, exp_am);
    check(int_value, exp_int);
    host_serial_model_inst.hold_off(17 * 24);
    b = band_cnt;
    wr({12'h000, iv, 4'h0});
    {exp_int, exp_fr, exp_af, exp_am} = {iv, fr, uf, lf, um, lm};
    check(int_value, exp_int);
    check(main_fraction, exp_fr);
    check(aux_fraction, exp_af);
    check(aux_modulus, exp_am);
    check(hold_oscillator_band, hold);
    check(band_cnt, b + (hold ? 0 : 1));
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    check(ref_divider, 10'h001);
    check(main_modulus, 25'h1000000);
    check(int_value, 16'h0000);
    check(adc_busy, 1'b0);
    retune(1'b1, 1'b0);
    repeat (60) @(posedge mclk);
    #1;
    check(resync_ticks, 5);
    check(adc_gap, 24);
    check(pfd_gap, 8);
    // Detector rate follows divider and halve bit, not the doubler
    for (int k = 0; k < 2; k++)
    begin
      wr({5'h00, k[0], k[0], 10'(2 - k), 11'h000, 4'h4});
      repeat (120) @(posedge mclk);
      #1;
      check(ref_divider, 10'(2 - k));
      check({ref_doubler, ref_halve}, {k[0], k[0]});
      check(pfd_gap, 16);
      check(adc_gap, 48);
    end
    wr({5'h00, 2'b00, 10'h001, 11'h000, 4'h4});
    for (int i = 0; i < 3; i++)
    begin
      wr(host_serial_model_inst.hold_word(i == 1));
      retune(1'b0, i == 1);
    end
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    check(ref_divider, 10'h001);
    check(int_value, 16'h0000);
    close_out();
  end
endmodule
